// ---- common/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

  localparam int unsigned CODE_W       = 12;
  localparam int unsigned PIPE_DEPTH   = 4;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned RECOVERY_NS  = 300;
  // Least time, so round up
  localparam int unsigned RECOVERY_CYC =
    (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REC_CNT_W    = $clog2(RECOVERY_CYC + 1);
  localparam logic [REC_CNT_W-1:0] REC_LOAD = REC_CNT_W'(RECOVERY_CYC);
  localparam logic [REC_CNT_W-1:0] REC_DONE = '0;
  localparam logic [CODE_W-1:0]    CODE_RST = 12'h000;

  typedef struct packed {
    logic              vld;
    logic [CODE_W-1:0] code;
  } sample_word_t;

endpackage : adc_ctrl_pkg

// ---- rtl/adc_output_ctrl.sv ----
`timescale 1ns/1ps
module adc_output_ctrl #(
  parameter int unsigned LATENCY = adc_ctrl_pkg::PIPE_DEPTH,
  parameter int unsigned FDEPTH  = adc_ctrl_pkg::FIFO_DEPTH
) (
  // Conversion clock and reset
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_n_i,
  // Control pins
  input  wire logic                            out_en_n_i,
  input  wire logic                            power_down_ctrl_i,
  // Quantiser result, two's complement
  input  wire logic [adc_ctrl_pkg::CODE_W-1:0] sample_i,
  // Data pins
  output logic      [adc_ctrl_pkg::CODE_W-1:0] data_o,
  output logic                                 data_oe_n_o,
  output logic                                 data_valid_o,
  output logic                                 fifo_ready_o
);

  localparam int unsigned W = adc_ctrl_pkg::CODE_W;

  adc_ctrl_pkg::sample_word_t pipe_r [LATENCY];
  adc_ctrl_pkg::sample_word_t fifo_out;
  logic [adc_ctrl_pkg::REC_CNT_W-1:0] rec_cnt_r;
  logic [W-1:0] data_r;
  logic         vld_r;
  logic         sample_ok;
  logic         fifo_vld;
  logic         drain_rdy;
  logic [W-1:0] ob_code;

  // Two's complement to offset binary is an MSB flip
  assign ob_code = {~sample_i[W-1], sample_i[W-2:0]};

  // Recovery window reloads every power-down cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rec_cnt_r <= adc_ctrl_pkg::REC_DONE;
    end else if (power_down_ctrl_i) begin
      rec_cnt_r <= adc_ctrl_pkg::REC_LOAD;
    end else if (rec_cnt_r != adc_ctrl_pkg::REC_DONE) begin
      rec_cnt_r <= rec_cnt_r - 1'b1;
    end
  end

  assign sample_ok = !power_down_ctrl_i && (rec_cnt_r == adc_ctrl_pkg::REC_DONE);

  // One sample enters every cycle, enable level plays no part
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      pipe_r[0] <= '{vld: sample_ok, code: ob_code};
      for (int i = 1; i < LATENCY; i++) begin
        pipe_r[i] <= '{vld: pipe_r[i-1].vld && !power_down_ctrl_i,
                       code: pipe_r[i-1].code};
      end
    end
  end

  // Drains every cycle outside power-down so latency stays fixed; words hidden by the enable are lost
  assign drain_rdy = !power_down_ctrl_i;

  word_fifo #(
    .WIDTH ($bits(adc_ctrl_pkg::sample_word_t)),
    .DEPTH (FDEPTH)
  ) word_fifo_i (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (power_down_ctrl_i),
    .in_valid_i  (pipe_r[LATENCY-1].vld),
    .in_ready_o  (fifo_ready_o),
    .in_data_i   (pipe_r[LATENCY-1]),
    .out_valid_o (fifo_vld),
    .out_ready_i (drain_rdy),
    .out_data_o  (fifo_out)
  );

  // Output register; cleared in power-down where pins carry nothing
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_r <= adc_ctrl_pkg::CODE_RST;
      vld_r  <= 1'b0;
    end else if (power_down_ctrl_i) begin
      data_r <= adc_ctrl_pkg::CODE_RST;
      vld_r  <= 1'b0;
    end else begin
      vld_r <= fifo_vld && drain_rdy;
      if (fifo_vld && drain_rdy) begin
        data_r <= fifo_out.code;
      end
    end
  end

  assign data_o       = data_r;
  assign data_oe_n_o  = out_en_n_i;
  assign data_valid_o = vld_r && !out_en_n_i && !power_down_ctrl_i;

  // Checking helpers
  localparam int unsigned LAT_TOT = LATENCY + 2;
  localparam logic [7:0] STEADY_MAX = 8'(LAT_TOT + 1);
  logic [7:0] steady_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      steady_r <= '0;
    end else if (!sample_ok || out_en_n_i) begin
      steady_r <= '0;
    end else if (steady_r != STEADY_MAX) begin
      steady_r <= steady_r + 1'b1;
    end
  end

  // Cycles since power-down was last seen, saturating at the recovery length
  logic [adc_ctrl_pkg::REC_CNT_W-1:0] pd_low_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_low_r <= adc_ctrl_pkg::REC_LOAD;
    end else if (power_down_ctrl_i) begin
      pd_low_r <= '0;
    end else if (pd_low_r != adc_ctrl_pkg::REC_LOAD) begin
      pd_low_r <= pd_low_r + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Pin enable
  AST_OE_RELEASE: assert property (out_en_n_i |-> data_oe_n_o && !data_valid_o)
    else $error("Data pins driven while enable high");

  AST_OE_DRIVE: assert property (!out_en_n_i |-> !data_oe_n_o)
    else $error("Data pins not driven while enable low");

  AST_VALID_GATE: assert property (
      data_valid_o |-> !out_en_n_i && !power_down_ctrl_i)
    else $error("Valid outside enabled period");

  // Conversion goes on behind released pins
  AST_CONVERT_ON: assert property (
      (steady_r == STEADY_MAX && !power_down_ctrl_i) ##1
      (out_en_n_i && !power_down_ctrl_i) [*3] |-> pipe_r[LATENCY-1].vld)
    else $error("Conversion stopped while outputs released");

  AST_HIDDEN_RUN: assert property (
      (steady_r == STEADY_MAX && !power_down_ctrl_i) ##1
      (out_en_n_i && !power_down_ctrl_i) [*3] |-> vld_r)
    else $error("Output register stalled while outputs released");

  AST_ENTRY: assert property (
      1'b1 |=> pipe_r[0].code == $past(ob_code))
    else $error("Sample not taken on this edge");

  // Power-down and recovery
  AST_PD_NOVALID: assert property (
      power_down_ctrl_i |=> !vld_r && data_r == '0)
    else $error("Valid word during power-down");

  AST_PD_FLUSH: assert property (
      power_down_ctrl_i ##1 !power_down_ctrl_i |-> !data_valid_o [*2])
    else $error("Stale pipeline word after power-down");

  AST_PIPE_KILL: assert property (
      power_down_ctrl_i |=> !pipe_r[LATENCY-1].vld)
    else $error("Pipeline word survived power-down");

  AST_FIFO_FLUSH: assert property (
      power_down_ctrl_i |=> !fifo_vld)
    else $error("Buffered word survived power-down");

  AST_REC_LOAD: assert property (
      power_down_ctrl_i |=> rec_cnt_r == adc_ctrl_pkg::REC_LOAD)
    else $error("Recovery window not restarted");

  AST_RECOVERY: assert property (
      $fell(power_down_ctrl_i) |-> !sample_ok [*8] ##1 !sample_ok [*6])
    else $error("Samples accepted inside recovery interval");

  AST_REC_WINDOW: assert property (
      pd_low_r != adc_ctrl_pkg::REC_LOAD |-> !sample_ok)
    else $error("Sample accepted before recovery ended");

  AST_RECOVERY_END: assert property (
      !power_down_ctrl_i && pd_low_r == adc_ctrl_pkg::REC_LOAD |-> sample_ok)
    else $error("Recovery interval too long");

  // Stream timing
  AST_LATENCY: assert property (
      data_valid_o && steady_r == STEADY_MAX
      |-> data_o == {~$past(sample_i[W-1], LAT_TOT), $past(sample_i[W-2:0], LAT_TOT)})
    else $error("Word latency or order wrong");

  AST_STREAM_ON: assert property (
      steady_r == STEADY_MAX && !out_en_n_i && !power_down_ctrl_i |-> data_valid_o)
    else $error("Word missing in steady stream");

  AST_NO_BACKLOG: assert property (fifo_ready_o)
    else $error("Buffer backed up, latency no longer fixed");

  AST_PIPE_SHIFT: assert property (
      1'b1 |=> pipe_r[LATENCY-1].code == $past(pipe_r[LATENCY-2].code))
    else $error("Pipeline order broken");

  // Output coding
  AST_MIDSCALE: assert property (
      sample_i == '0 |-> ob_code == {1'b1, {(W-1){1'b0}}})
    else $error("Mid-scale code wrong");

  AST_FULLSCALE_LO: assert property (
      sample_i == {1'b1, {(W-1){1'b0}}} |-> ob_code == '0)
    else $error("Negative full-scale code wrong");

  AST_FULLSCALE_HI: assert property (
      sample_i == {1'b0, {(W-1){1'b1}}} |-> ob_code == '1)
    else $error("Positive full-scale code wrong");

endmodule : adc_output_ctrl

// ---- rtl/word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_LVL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      level_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (level_r != FULL_LVL);
  assign out_valid_o = (level_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        level_r <= level_r + 1'b1;
      end else if (pop && !push) begin
        level_r <= level_r - 1'b1;
      end
    end
  end

endmodule : word_fifo

// ---- tb/adc_output_ctrl_test.sv ----
`timescale 1ns/1ps
module adc_output_ctrl_test;
  logic        sys_clk_i         = 1'b0;
  logic        rst_n_i           = 1'b0;
  logic        out_en_n_i        = 1'b0;
  logic        power_down_ctrl_i = 1'b0;
  logic [11:0] sample_i          = 12'h000;
  logic [11:0] data_o;
  logic        data_oe_n_o;
  logic        data_valid_o;
  logic        fifo_ready_o;
  logic [11:0] hist [0:5];
  logic [11:0] pending[$];
  int          mismatches = 0;
  int          checked    = 0;
  int          cyc        = 0;

  // Free-running 50 MHz, even duty
  always #10 sys_clk_i = ~sys_clk_i;

  adc_output_ctrl adc_output_ctrl_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .out_en_n_i(out_en_n_i),
    .power_down_ctrl_i(power_down_ctrl_i), .sample_i(sample_i), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .data_valid_o(data_valid_o), .fifo_ready_o(fifo_ready_o));

  word_receiver word_receiver_i (
    .sys_clk_i(sys_clk_i), .data_i(data_o), .oe_n_i(data_oe_n_o), .valid_i(data_valid_o));

  // Counting samples make order and drops visible
  always @(posedge sys_clk_i) begin
    hist[0] <= sample_i;
    for (int i = 1; i < 6; i++) begin
      hist[i] <= hist[i-1];
    end
    sample_i <= (pending.size() != 0) ? pending.pop_front() : sample_i + 12'h001;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic stream_test;
    pending = '{12'h800, 12'h7ff, 12'h000};
    repeat (12) begin
      @(negedge sys_clk_i);
      check(data_valid_o, 1'b1);
      check(data_o, hist[5] ^ 12'h800);
    end
  endtask : stream_test

  task automatic enable_test;
    @(posedge sys_clk_i) out_en_n_i <= 1'b1;
    repeat (10) begin
      @(negedge sys_clk_i);
      check(data_oe_n_o, 1'b1);
      check(data_valid_o, 1'b0);
    end
    check(fifo_ready_o, 1'b1);
    check(data_o, hist[5] ^ 12'h800);
    word_receiver_i.words.delete();
    @(posedge sys_clk_i) out_en_n_i <= 1'b0;
    repeat (8) @(negedge sys_clk_i);
    check(data_oe_n_o, 1'b0);
    check(data_o, hist[5] ^ 12'h800);
    for (int i = 1; i < 4; i++) begin
      check(word_receiver_i.words[i], word_receiver_i.words[i-1] + 12'h001);
    end
    check(word_receiver_i.words[4] == word_receiver_i.words[3] + 12'h001, 1'b1);
  endtask : enable_test

  task automatic power_down_test;
    int n;
    @(posedge sys_clk_i) power_down_ctrl_i <= 1'b1;
    @(negedge sys_clk_i);
    check(data_valid_o, 1'b0);
    repeat (8) begin
      @(negedge sys_clk_i);
      check(data_valid_o, 1'b0);
      check(data_o, 12'h000);
    end
    @(posedge sys_clk_i) power_down_ctrl_i <= 1'b0;
    n = 0;
    while (data_valid_o !== 1'b1 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    check(n >= 20 && n < 30, 1'b1);
    check(data_o, hist[5] ^ 12'h800);
  endtask : power_down_test

  task automatic finish_test;
    $display("mismatches %0d, checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(negedge sys_clk_i);
    stream_test();
    enable_test();
    power_down_test();
    stream_test();
    finish_test();
  end
endmodule : adc_output_ctrl_test

// ---- tb/word_receiver.sv ----
`timescale 1ns/1ps
module word_receiver (
  // Conversion clock
  input  wire logic                            sys_clk_i,
  // Converter pins
  input  wire logic [adc_ctrl_pkg::CODE_W-1:0] data_i,
  input  wire logic                            oe_n_i,
  input  wire logic                            valid_i
);
  logic [adc_ctrl_pkg::CODE_W-1:0] words[$];
  logic [adc_ctrl_pkg::CODE_W-1:0] pin_word;

  // Released pins float; show a wrong word so a careless latch is caught
  assign pin_word = (oe_n_i === 1'b0) ? data_i : ~data_i;

  // Rising-edge latch; idle or recovering periods carry nothing
  always @(posedge sys_clk_i) begin
    if (valid_i === 1'b1 && oe_n_i === 1'b0) begin
      words.push_back(pin_word);
    end
  end
endmodule : word_receiver
